// ### common/apc_pkg.sv
// Package for the converter port and coincidence logic.
// Assumes a 25 MHz system clock and an Avalon-MM register master.
package apc_pkg;

  // ==========================================================
  // Clocking and timing
  localparam int CLK_HZ         = 25000000;
  localparam int TICK_HZ        = 10000000;
  localparam int LIVE_PERIOD_US = 1000;
  localparam int LIVE_CYCLES    = (CLK_HZ / 1000000) * LIVE_PERIOD_US;
  localparam int DEAD_LEAD_NS   = 200;
  // Extra drive cycles so the synchronised data lines show the result
  localparam logic [1:0] DRIVE_SETTLE = 2'h2;

  // ==========================================================
  // Register word offsets (byte address = 4 * index)
  localparam logic [3:0] REG_MODE    = 4'h0;
  localparam logic [3:0] REG_POL     = 4'h1;
  localparam logic [3:0] REG_WINDOW  = 4'h2;
  localparam logic [3:0] REG_TIMEOUT = 4'h3;
  localparam logic [3:0] REG_STATUS  = 4'h4;
  localparam logic [3:0] REG_STREAM  = 4'h5;

  // ==========================================================
  // Polarity register field positions (4 bits each, one per port)
  localparam int POL_READY  = 0;
  localparam int POL_ACCEPT = 4;
  localparam int POL_DEAD   = 8;
  localparam int POL_CONV   = 12;
  localparam int POL_DRIVE  = 16;
  localparam int POL_EDGE   = 20;

  // Mode register: bits 3:0 coincidence per port, 7:4 window starters,
  // bit 8 arm
  localparam int MODE_COINC = 0;
  localparam int MODE_START = 4;
  localparam int MODE_ARM   = 8;

  localparam logic [31:0] RST_POL     = 32'h0000_0000;
  localparam logic [31:0] RST_WINDOW  = 32'h0000_0019;
  localparam logic [31:0] RST_TIMEOUT = 32'h0000_00fa;

  // ==========================================================
  // Stream word header codes (bits 31:28)
  localparam logic [3:0] HDR_SYNC   = 4'hf;
  localparam logic [3:0] HDR_SINGLE = 4'h1;
  localparam logic [3:0] HDR_COINC  = 4'h2;
  localparam logic [3:0] HDR_LIVE   = 4'h3;
  localparam logic [3:0] HDR_DATA   = 4'h4;
  localparam logic [27:0] SYNC_WORD = 28'hfff_ffff;

  typedef enum {
    APC_HS_IDLE,
    APC_HS_DRIVE,
    APC_HS_LATCH,
    APC_HS_ACCEPT
  } apc_hs_state_t;

  typedef enum {
    APC_CO_IDLE,
    APC_CO_WINDOW,
    APC_CO_WAIT,
    APC_CO_SEND
  } apc_co_state_t;

endpackage

// ### logic/apc_sync.sv
// Two flip-flop synchroniser for a bus of pin levels.
// Assumes inputs asynchronous to clk.
`timescale 1ns/1ps
module apc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } apc_sync_st_t;

  apc_sync_st_t st;
  apc_sync_st_t next_st;

  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;
endmodule // apc_sync

// ### logic/apc_port.sv
// One converter port: handshake, result register and busy flag.
// Assumes ready synchronised by the caller and levels already
// normalised to active high.
`timescale 1ns/1ps
module apc_port (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ready,
  input  wire logic [15:0] raw_data,
  input  wire logic        coinc,
  input  wire logic        window_open,
  input  wire logic        take,
  input  wire logic        arm,
  output logic             accept,
  output logic             drive,
  output logic             conv_en,
  output logic             busy,
  output logic      [15:0] result
);
  typedef struct packed {
    apc_pkg::apc_hs_state_t hs;
    logic [1:0]             settle;
    logic                   busy;
    logic                   hold;
    logic [15:0]            result;
  } apc_port_st_t;

  apc_port_st_t st;
  apc_port_st_t next_st;

  always_comb begin
    next_st = st;
    // Collector read frees the register, but a latch in the
    // same cycle still sees busy set and its result is dropped
    if (take) begin
      next_st.busy = 1'b0;
      next_st.hold = 1'b0;
    end
    case (st.hs)
      apc_pkg::APC_HS_IDLE: begin
        // In coincidence mode data outside a window is not taken
        if (ready && (!coinc || window_open)) begin
          next_st.hs     = apc_pkg::APC_HS_DRIVE;
          next_st.settle = 2'h0;
        end
      end
      apc_pkg::APC_HS_DRIVE: begin
        // Driver settle plus the two data synchroniser stages
        if (st.settle == apc_pkg::DRIVE_SETTLE) begin
          next_st.hs = apc_pkg::APC_HS_LATCH;
        end else begin
          next_st.settle = st.settle + 2'h1;
        end
      end
      apc_pkg::APC_HS_LATCH: begin
        if (!st.busy) begin
          next_st.result = ~raw_data;
          next_st.busy   = 1'b1;
          next_st.hold   = coinc;
        end
        next_st.hs = apc_pkg::APC_HS_ACCEPT;
      end
      apc_pkg::APC_HS_ACCEPT: begin
        if (!ready) begin
          next_st.hs = apc_pkg::APC_HS_IDLE;
        end
      end
      default: next_st.hs = apc_pkg::APC_HS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '{hs: apc_pkg::APC_HS_IDLE, settle: 2'h0, busy: 1'b0,
              hold: 1'b0, result: 16'h0000};
    end else begin
      st <= next_st;
    end
  end

  assign accept  = (st.hs == apc_pkg::APC_HS_ACCEPT);
  assign drive   = (st.hs == apc_pkg::APC_HS_DRIVE) ||
                   (st.hs == apc_pkg::APC_HS_LATCH);
  assign conv_en = arm && !st.hold;
  assign busy    = st.busy;
  assign result  = st.result;
endmodule // apc_port

// ### logic/apc_top.sv
// Four converter ports with single and coincidence collection,
// live-time sampling and a listmode word stream read over Avalon-MM.
// Assumes all converter pins asynchronous to the 25 MHz clk.
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module apc_top #(
  parameter int NPORT       = 4,
  parameter int LIVE_CYCLES = apc_pkg::LIVE_CYCLES
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [3:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic      [31:0]      avs_readdata,
  output logic                  avs_waitrequest,
  input  wire logic [16*4-1:0]  conv_result_lines,
  input  wire logic [3:0]       adc_data_ready,
  input  wire logic [3:0]       dead_time,
  output logic      [3:0]       data_accepted,
  output logic      [3:0]       convert_enable,
  output logic      [3:0]       output_drive_enable
);

  if (NPORT != 4) begin : g_bad_nport
    $error("apc_top supports exactly four ports");
  end
  if (LIVE_CYCLES < 2) begin : g_bad_live
    $error("LIVE_CYCLES too small");
  end

  // ==========================================================
  // Pin synchronisers
  logic [3:0] ready_raw;
  logic [3:0] dead_raw;
  logic [63:0] lines_q;

  apc_sync #(.W(8)) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({dead_time, adc_data_ready}),
    .q     ({dead_raw, ready_raw})
  );

  // Data lines too; the port stretches drive to cover both stages
  apc_sync #(.W(64)) u_data_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (conv_result_lines),
    .q     (lines_q)
  );

  // ==========================================================
  // State
  typedef struct packed {
    logic [31:0]            mode;
    logic [31:0]            pol;
    logic [15:0]            window;
    logic [15:0]            timeout;
    logic [3:0]             dead_q;
    apc_pkg::apc_co_state_t co;
    logic [15:0]            cnt;
    logic [3:0]             seen;
    logic [3:0]             take;
    logic [31:0]            live_cnt;
    logic                   live_due;
    logic [3:0]             live_img;
    logic [2:0]             send_idx;
    logic                   send_coinc;
    logic [3:0]             send_set;
    logic [63:0]            send_data;
    logic [31:0]            out_word;
    logic                   out_valid;
    logic                   rdack;
    logic [31:0]            rdata;
    logic [3:0]             acc_o;
    logic [3:0]             conv_o;
    logic [3:0]             drv_o;
  } apc_top_st_t;

  apc_top_st_t st;
  apc_top_st_t next_st;

  // ==========================================================
  // Ports
  logic [3:0]  ready_n;
  logic [3:0]  dead_n;
  logic [3:0]  p_acc;
  logic [3:0]  p_drv;
  logic [3:0]  p_conv;
  logic [3:0]  p_busy;
  logic [63:0] p_res;
  logic        win_open;

  // Normalise pin polarity once so the ports work active high
  assign ready_n  = ready_raw ^ st.pol[apc_pkg::POL_READY +: 4];
  assign dead_n   = dead_raw ^ st.pol[apc_pkg::POL_DEAD +: 4];
  assign win_open = (st.co == apc_pkg::APC_CO_WINDOW);

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_port
      apc_port u_port (
        .clk         (clk),
        .rst_b       (rst_b),
        .ready       (ready_n[g]),
        .raw_data    (lines_q[16*g +: 16]),
        .coinc       (st.mode[apc_pkg::MODE_COINC + g]),
        .window_open (win_open),
        .take        (st.take[g]),
        .arm         (st.mode[apc_pkg::MODE_ARM]),
        .accept      (p_acc[g]),
        .drive       (p_drv[g]),
        .conv_en     (p_conv[g]),
        .busy        (p_busy[g]),
        .result      (p_res[16*g +: 16])
      );
    end
  endgenerate

  // ==========================================================
  // Helpers
  function automatic logic [31:0] apc_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = wd[8*i +: 8];
    end
    return r;
  endfunction

  function automatic logic [31:0] apc_word(input logic [3:0]  hdr,
                                           input logic [27:0] body);
    return {hdr, body};
  endfunction

  logic [3:0] edges;
  logic [3:0] coinc_ports;
  logic [3:0] single_ready;
  logic [3:0] pend;
  logic [1:0] sel;

  always_comb begin
    coinc_ports = st.mode[apc_pkg::MODE_COINC +: 4];
    // Rising edge in the normalised sense; the edge select flips it
    edges = (dead_n & ~st.dead_q) ^
            (st.pol[apc_pkg::POL_EDGE +: 4] & (dead_n ^ st.dead_q));
    single_ready = p_busy & ~coinc_ports;
    pend = st.send_set;
    sel  = 2'd0;
    for (int i = 3; i >= 0; i--) begin
      if (pend[i]) sel = 2'(i);
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_st      = st;
    next_st.take = 4'h0;
    next_st.rdack = 1'b0;
    next_st.dead_q = dead_n;
    next_st.acc_o  = p_acc ^ st.pol[apc_pkg::POL_ACCEPT +: 4];
    next_st.conv_o = p_conv ^ st.pol[apc_pkg::POL_CONV +: 4];
    next_st.drv_o  = p_drv ^ st.pol[apc_pkg::POL_DRIVE +: 4];

    // Live-time tick; a due image waits if the stream is busy
    if (st.live_cnt >= 32'(LIVE_CYCLES - 1)) begin
      next_st.live_cnt = 32'h0;
      next_st.live_due = 1'b1;
      next_st.live_img = ~dead_n;
    end else begin
      next_st.live_cnt = st.live_cnt + 32'h1;
    end

    // Register bus: one wait cycle, answer on the next edge
    if (avs_write && !st.rdack) begin
      next_st.rdack = 1'b1;
      if (avs_address == apc_pkg::REG_MODE) begin
        next_st.mode = apc_merge(st.mode, avs_writedata, avs_byteenable);
      end else if (avs_address == apc_pkg::REG_POL) begin
        next_st.pol = apc_merge(st.pol, avs_writedata, avs_byteenable);
      end else if (avs_address == apc_pkg::REG_WINDOW) begin
        next_st.window = 16'(apc_merge({16'h0, st.window}, avs_writedata,
                                       avs_byteenable));
      end else if (avs_address == apc_pkg::REG_TIMEOUT) begin
        next_st.timeout = 16'(apc_merge({16'h0, st.timeout}, avs_writedata,
                                        avs_byteenable));
      end
    end else if (avs_read && !st.rdack) begin
      next_st.rdack = 1'b1;
      next_st.rdata = 32'h0;
      if (avs_address == apc_pkg::REG_MODE) begin
        next_st.rdata = st.mode;
      end else if (avs_address == apc_pkg::REG_POL) begin
        next_st.rdata = st.pol;
      end else if (avs_address == apc_pkg::REG_WINDOW) begin
        next_st.rdata = {16'h0, st.window};
      end else if (avs_address == apc_pkg::REG_TIMEOUT) begin
        next_st.rdata = {16'h0, st.timeout};
      end else if (avs_address == apc_pkg::REG_STATUS) begin
        next_st.rdata = {20'h0, st.seen, p_busy, 1'b0, st.out_valid,
                         2'(st.co)};
      end else if (avs_address == apc_pkg::REG_STREAM) begin
        next_st.rdata = st.out_valid ? st.out_word : 32'h0;
        next_st.out_valid = 1'b0;
      end
    end

    // Coincidence and stream sequencer
    case (st.co)
      apc_pkg::APC_CO_IDLE: begin
        // A word waiting in the stream must not swallow an event edge
        if (|(edges & coinc_ports & st.mode[apc_pkg::MODE_START +: 4]))
        begin
          next_st.co   = apc_pkg::APC_CO_WINDOW;
          next_st.seen = edges & coinc_ports;
          next_st.cnt  = 16'h0;
        end else if (!next_st.out_valid && st.live_due) begin
          next_st.live_due  = 1'b0;
          next_st.out_word  = apc_word(apc_pkg::HDR_LIVE,
                                       {24'h0, st.live_img});
          next_st.out_valid = 1'b1;
        end else if (!next_st.out_valid && |single_ready) begin
          // Everything ready now leaves as one block
          next_st.send_set   = single_ready;
          next_st.send_data  = p_res;
          next_st.take       = single_ready;
          next_st.send_coinc = 1'b0;
          next_st.send_idx   = 3'd0;
          next_st.co         = apc_pkg::APC_CO_SEND;
        end
      end
      apc_pkg::APC_CO_WINDOW: begin
        next_st.seen = st.seen | (edges & coinc_ports);
        if (st.cnt >= st.window) begin
          next_st.co  = apc_pkg::APC_CO_WAIT;
          next_st.cnt = 16'h0;
        end else begin
          next_st.cnt = st.cnt + 16'h1;
        end
      end
      apc_pkg::APC_CO_WAIT: begin
        if (((p_busy & st.seen) == st.seen) ||
            (st.cnt >= st.timeout)) begin
          next_st.send_set   = st.seen;
          next_st.take       = st.seen;
          next_st.send_coinc = 1'b1;
          next_st.send_idx   = 3'd0;
          for (int i = 0; i < 4; i++) begin
            next_st.send_data[16*i +: 16] =
              p_busy[i] ? p_res[16*i +: 16] : 16'h0000;
          end
          next_st.co = apc_pkg::APC_CO_SEND;
        end else begin
          next_st.cnt = st.cnt + 16'h1;
        end
      end
      apc_pkg::APC_CO_SEND: begin
        // Block: sync word, header, then one word per port in the set
        if (!next_st.out_valid) begin
          next_st.out_valid = 1'b1;
          if (st.send_idx == 3'd0) begin
            next_st.out_word = apc_word(apc_pkg::HDR_SYNC,
                                        apc_pkg::SYNC_WORD);
            next_st.send_idx = 3'd1;
          end else if (st.send_idx == 3'd1) begin
            next_st.out_word = apc_word(st.send_coinc ? apc_pkg::HDR_COINC
                                        : apc_pkg::HDR_SINGLE,
                                        {24'h0, st.send_set});
            next_st.send_idx = 3'd2;
          end else begin
            next_st.out_word = apc_word(apc_pkg::HDR_DATA,
                                        {10'h0, sel,
                                         st.send_data[16*sel +: 16]});
            next_st.send_set = pend & ~(4'h1 << sel);
            if ((pend & ~(4'h1 << sel)) == 4'h0) begin
              next_st.co   = apc_pkg::APC_CO_IDLE;
              next_st.seen = 4'h0;
            end
          end
        end
      end
      default: next_st.co = apc_pkg::APC_CO_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st         <= '0;
      st.co      <= apc_pkg::APC_CO_IDLE;
      st.pol     <= apc_pkg::RST_POL;
      st.window  <= apc_pkg::RST_WINDOW[15:0];
      st.timeout <= apc_pkg::RST_TIMEOUT[15:0];
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  assign avs_readdata        = st.rdata;
  assign avs_waitrequest     = !st.rdack;
  assign data_accepted       = st.acc_o;
  assign convert_enable      = st.conv_o;
  assign output_drive_enable = st.drv_o;
endmodule // apc_top

// ### dv/apc_top_props.sv
// Checker for the converter port block, watching its top ports.
// Assumes the register map of apc_pkg and a single clock domain.
`timescale 1ns/1ps
module apc_top_props (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  input  wire logic [3:0]  adc_data_ready,
  input  wire logic [3:0]  data_accepted,
  input  wire logic [3:0]  convert_enable,
  input  wire logic [3:0]  output_drive_enable
);
  // ==========================================================
  // Shadow polarity and mode; go quiet while outputs re-settle
  logic [31:0] pol;
  logic [31:0] mode;
  logic [2:0]  quiet;
  logic        wr_ok;
  logic [3:0]  rdy;
  logic [3:0]  acc;
  logic [3:0]  drv;
  logic [3:0]  conv;
  assign wr_ok = avs_write && !avs_waitrequest;
  assign rdy   = adc_data_ready ^ pol[3:0];
  assign acc   = data_accepted ^ pol[7:4];
  assign conv  = convert_enable ^ pol[15:12];
  assign drv   = output_drive_enable ^ pol[19:16];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pol   <= apc_pkg::RST_POL;
      mode  <= 32'h0;
      quiet <= 3'h0;
    end else begin
      if (wr_ok && avs_address == apc_pkg::REG_POL) pol <= avs_writedata;
      if (wr_ok && avs_address == apc_pkg::REG_MODE) mode <= avs_writedata;
      if (wr_ok && avs_address < 4'h2) quiet <= 3'h5;
      else if (quiet != 3'h0) quiet <= quiet - 3'h1;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b || quiet != 3'h0);
  AST_BUS_ANSWER:
    assert property ((avs_read || avs_write) && avs_waitrequest
      |-> ##[1:2] !avs_waitrequest) else $error("bus answer late");
  AST_WAIT_PULSE:
    assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
  AST_UNMAPPED_ZERO:
    assert property (avs_read && !avs_waitrequest && avs_address > 4'h5
      |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  for (genvar g = 0; g < 4; g++) begin : gp
    AST_ACC_AFTER_READY:
      assert property ($rose(acc[g]) |-> $past(rdy[g], 2))
        else $error("accept without data ready");
    AST_ACC_HOLD:
      assert property (acc[g] && rdy[g] |=> acc[g])
        else $error("accept dropped while ready held");
    AST_ACC_DROP:
      assert property ($fell(rdy[g]) |-> ##[1:5] !acc[g])
        else $error("accept not withdrawn");
    AST_DRIVE_BEFORE_ACC:
      assert property ($rose(acc[g]) |-> $past(drv[g], 1) || $past(drv[g], 2))
        else $error("result taken without drive enable");
    AST_DRIVE_WITH_READY:
      assert property (drv[g] |-> rdy[g])
        else $error("drive enable without data ready");
    AST_CONV_OFF:
      assert property ($rose(acc[g]) && mode[g] |-> ##[0:2] !conv[g])
        else $error("convert enable kept after latch");
  end
  cover property ($rose(acc[0]) && mode[0]);
  cover property ($rose(acc[2]) && !mode[2]);
  cover property (avs_read && !avs_waitrequest && avs_address > 4'h5);
endmodule // apc_top_props

bind apc_top apc_top_props u_props (
  .clk(clk), .rst_b(rst_b), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .adc_data_ready(adc_data_ready),
  .data_accepted(data_accepted), .convert_enable(convert_enable),
  .output_drive_enable(output_drive_enable)
);

// ### dv/apc_conv_model.sv
// Behavioural converter on one port: dead time, data ready, result.
// Assumes every port polarity at its reset (active high) setting.
`timescale 1ns/1ps
module apc_conv_model (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [15:0] val,
  input  wire logic        no_rdy,
  input  wire logic [3:0]  lag,
  input  wire logic        accept,
  input  wire logic        drive,
  input  wire logic        conv,
  output logic             ready,
  output logic             dead,
  output logic      [15:0] lines,
  output logic             done,
  output logic             got_acc
);
  logic [15:0] v;
  int          n;
  // Driven lines show the inverse, so a read without drive never looks right
  assign lines = drive ? ~v : v;
  initial begin
    ready   = 1'b0;
    dead    = 1'b0;
    done    = 1'b0;
    got_acc = 1'b0;
    v       = 16'h0;
    forever begin
      @(posedge clk);
      if (go) begin
        done    <= 1'b0;
        got_acc <= 1'b0;
        v       <= val;
        for (n = 0; n < 50 && conv !== 1'b1; n++) @(posedge clk);
        dead <= 1'b1;
        repeat (6) @(posedge clk);
        if (!no_rdy) begin
          ready <= 1'b1;
          for (n = 0; n < 40 && accept !== 1'b1; n++) @(posedge clk);
          got_acc <= accept;
          repeat (lag) @(posedge clk);
          ready <= 1'b0;
          for (n = 0; n < 20 && accept !== 1'b0; n++) @(posedge clk);
        end else begin
          repeat (20) @(posedge clk);
        end
        dead <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule // apc_conv_model

// ### dv/test_adc_port_coincidence_logic.sv
// Testbench: register bus tasks, four converter models, stream checks.
// Assumes apc_top with a shortened live-time period.
`timescale 1ns/1ps
module test_adc_port_coincidence_logic;
  logic        clk;
  logic        rst_b;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  wire  [63:0] conv_result_lines;
  wire  [3:0]  adc_data_ready;
  wire  [3:0]  dead_time;
  wire  [3:0]  done;
  wire  [3:0]  got;
  logic [3:0]  data_accepted;
  logic [3:0]  convert_enable;
  logic [3:0]  output_drive_enable;
  logic [3:0]  go;
  logic [3:0]  no_rdy;
  logic [3:0]  lag;
  logic [15:0] val [4];
  logic [31:0] q;
  logic [27:0] b;
  logic [3:0]  p;
  int          n_fail = 0;
  int          checked = 0;
  int          cyc = 0;

  // ==========================================================
  // Design and converters
  apc_top #(.NPORT(4), .LIVE_CYCLES(400)) DUT (
    .clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .conv_result_lines(conv_result_lines), .adc_data_ready(adc_data_ready),
    .dead_time(dead_time), .data_accepted(data_accepted),
    .convert_enable(convert_enable),
    .output_drive_enable(output_drive_enable)
  );
  for (genvar i = 0; i < 4; i++) begin : gm
    apc_conv_model u_m (
      .clk(clk), .go(go[i]), .val(val[i]), .no_rdy(no_rdy[i]), .lag(lag),
      .accept(data_accepted[i]), .drive(output_drive_enable[i]),
      .conv(convert_enable[i]), .ready(adc_data_ready[i]),
      .dead(dead_time[i]), .lines(conv_result_lines[16*i +: 16]),
      .done(done[i]), .got_acc(got[i])
    );
  end

  // ==========================================================
  // Tasks
  task automatic summarize();
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Request held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    r = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 100) chk(32'h1, 32'h0);
    @(posedge clk);
  endtask
  // Pops stream words until the wanted header; ph is the one before it
  task automatic pop(input logic [3:0] h, output logic [27:0] bd,
                     output logic [3:0] ph);
    logic [31:0] w;
    int n;
    w  = 32'h0;
    ph = 4'h0;
    for (n = 0; n < 64 && w[31:28] !== h; n++) begin
      ph = w[31:28];
      bus(1'b0, apc_pkg::REG_STREAM, 32'h0, w);
    end
    chk({28'h0, w[31:28]}, {28'h0, h});
    bd = w[27:0];
  endtask
  task automatic fire(input logic [3:0] m, input logic [3:0] nr);
    int n;
    go     <= m;
    no_rdy <= nr;
    @(posedge clk);
    go <= 4'h0;
    @(posedge clk);
    for (n = 0; n < 600 && (done & m) !== m; n++) @(posedge clk);
  endtask

  // ==========================================================
  // Clock, timeout and sequence
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    rst_b = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    go = 4'h0;
    no_rdy = 4'h0;
    lag = 4'h0;
    val = '{16'h0, 16'h0, 16'h0, 16'h0};
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk({20'h0, data_accepted, output_drive_enable, convert_enable}, 32'h0);
    bus(1'b0, apc_pkg::REG_POL, 32'h0, q);
    chk(q, apc_pkg::RST_POL);
    bus(1'b0, apc_pkg::REG_WINDOW, 32'h0, q);
    chk(q, apc_pkg::RST_WINDOW);
    bus(1'b0, apc_pkg::REG_TIMEOUT, 32'h0, q);
    chk(q, apc_pkg::RST_TIMEOUT);
    bus(1'b0, 4'hf, 32'h0, q);
    chk(q, 32'h0);
    // Inverted accept, convert and drive show in the idle levels
    bus(1'b1, apc_pkg::REG_POL, 32'h000f_f0f0, q);
    repeat (4) @(posedge clk);
    chk({20'h0, data_accepted, output_drive_enable, convert_enable},
        32'h0000_0fff);
    bus(1'b1, apc_pkg::REG_POL, 32'h0, q);
    repeat (450) @(posedge clk);
    pop(apc_pkg::HDR_LIVE, b, p);
    chk({28'h0, b[3:0]}, 32'hf);
    // Two single ports together, slow to drop ready
    bus(1'b1, apc_pkg::REG_MODE, 32'h0000_0100, q);
    repeat (4) @(posedge clk);
    chk({28'h0, convert_enable}, 32'hf);
    val[0] <= 16'h1234;
    val[1] <= 16'hedcb;
    lag    <= 4'h6;
    fire(4'h3, 4'h0);
    pop(apc_pkg::HDR_SINGLE, b, p);
    chk({28'h0, p}, {28'h0, apc_pkg::HDR_SYNC});
    chk({28'h0, b[3:0]}, 32'h3);
    pop(apc_pkg::HDR_DATA, b, p);
    chk({4'h0, b}, {14'h0, 2'd0, 16'h1234});
    pop(apc_pkg::HDR_DATA, b, p);
    chk({4'h0, b}, {14'h0, 2'd1, 16'hedcb});
    // Ports 0 and 1 coincidence, only port 0 opens a window
    lag <= 4'h0;
    bus(1'b1, apc_pkg::REG_MODE, 32'h0000_0113, q);
    val[2] <= 16'h0f0f;
    fire(4'h4, 4'h0);
    pop(apc_pkg::HDR_SINGLE, b, p);
    chk({28'h0, b[3:0]}, 32'h4);
    pop(apc_pkg::HDR_DATA, b, p);
    chk({4'h0, b}, {14'h0, 2'd2, 16'h0f0f});
    fire(4'h2, 4'h0);
    chk({31'h0, got[1]}, 32'h0);
    val[0] <= 16'h8001;
    go     <= 4'h1;
    @(posedge clk);
    fire(4'h2, 4'h2);
    repeat (300) @(posedge clk);
    pop(apc_pkg::HDR_COINC, b, p);
    chk({28'h0, b[3:0]}, 32'h3);
    pop(apc_pkg::HDR_DATA, b, p);
    chk({4'h0, b}, {14'h0, 2'd0, 16'h8001});
    pop(apc_pkg::HDR_DATA, b, p);
    chk({4'h0, b}, {14'h0, 2'd1, 16'h0000});
    // A window without data stalls the stream; port 3 stays busy
    fire(4'h1, 4'h1);
    val[3] <= 16'h0a0a;
    fire(4'h8, 4'h0);
    val[3] <= 16'h0c0c;
    fire(4'h8, 4'h0);
    chk({31'h0, got[3]}, 32'h1);
    repeat (200) @(posedge clk);
    pop(apc_pkg::HDR_SINGLE, b, p);
    pop(apc_pkg::HDR_DATA, b, p);
    chk({4'h0, b}, {14'h0, 2'd3, 16'h0a0a});
    summarize();
  end
endmodule // test_adc_port_coincidence_logic
